// ### rtl/cslps_pkg.sv
package cslps_pkg;

    // synchronised pin vector layout
    localparam int PIN_W = 9;
    localparam int P_RST = 0;
    localparam int P_STOP_CLOCK_REQUEST_N = 1;
    localparam int P_SMI = 2;
    localparam int P_INIT = 3;
    localparam int P_LINT0 = 4;
    localparam int P_LINT1 = 5;
    localparam int P_BIST = 6;
    localparam int P_PARK = 7;
    localparam int P_ARB = 8;
    // every pin idle: active-low pins high, local interrupt pins low
    localparam logic [PIN_W-1:0] PIN_IDLE = 9'h1cf;

    // event vector: smi, warm restart, local interrupt 0 and 1
    localparam int EVT_W = 4;

    // stop-grant entry delay in bus clocks after the acknowledge response
    localparam int SG_DELAY_CLKS = 20;

    localparam int NCORES_DEF = 2;
    localparam int RATIO_W = 8;
    localparam int VID_W = 6;
    // arbitrary operating points; real values come from the fused part
    localparam logic [RATIO_W-1:0] RATED_RATIO_DEF = 8'h0a;
    localparam logic [RATIO_W-1:0] LOW_RATIO_DEF = 8'h06;
    localparam logic [VID_W-1:0] VID_NOM_DEF = 6'h20;
    localparam logic [VID_W-1:0] VID_LOW_DEF = 6'h10;

    // register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STRAP = 8'h08;
    localparam int CTRL_EHALT_BIT = 0;
    localparam int CTRL_RATIO_LSB = 8;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_RLOW_BIT = 4;
    localparam int STAT_VLOW_BIT = 5;
    localparam int STAT_PEND_LSB = 8;

    typedef enum logic [3:0] {
        ST_NORMAL,
        ST_HALT,
        ST_EH_RATIO,
        ST_EHALT,
        ST_EH_VID,
        ST_SGACK,
        ST_SG_CNT,
        ST_STOP_GRANT,
        ST_HALT_SNOOP,
        ST_SG_SNOOP
    } cslps_state_e;

    // captured straps, 1 = option selected
    typedef struct packed {
        logic arb_id;
        logic park_disable;
        logic self_test;
        logic out_tristate;
    } cslps_strap_s;

    localparam cslps_strap_s STRAP_RST = 4'h0;

endpackage

// ### rtl/cslps_pin_sync.sv
`timescale 1ns/1ps
module cslps_pin_sync import cslps_pkg::*; #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic sys_clk_in, // bus clock
    input wire logic arst_n_in, // async reset, active low
    input wire logic [WIDTH-1:0] pin_in, // raw pins
    output logic [WIDTH-1:0] stable_out // filtered level
);

    initial begin
        if (WIDTH < 1) $error("cslps_pin_sync: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] s1_q, s2_q, s3_q, stable_q, stable_d;

    // a bit moves only when stages two and three agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            stable_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : stable_q[i];
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            stable_q <= RST_VAL;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            stable_q <= stable_d;
        end
    end

    assign stable_out = stable_q;

endmodule // cslps_pin_sync

// ### rtl/cslps_core.sv
// Function
// - capture the straps when the reset pin is released and use them afterwards.
// - straps stay fixed until the next reset; every reset acts alike.
// - asserted strap pins select tristate, self test, no parking, arbitration id.
// - production parts lock the bus ratio; only engineering samples may choose it.
// - enter HALT only once every core has halted or waits.
// - leave HALT for Normal on any interrupt event; reset initialises at once.
// - stop clock during HALT returns to HALT once released.
// - extended halt enable picks Extended HALT instead of plain HALT.
// - extended halt entry lowers ratio first, then the voltage code.
// - extended halt exit restores voltage code first, then the ratio.
// - snoops are still serviced in Extended HALT.
// - Stop-Grant begins exactly 20 clocks after the acknowledge response.
// - reset in Stop-Grant initialises but stays; stop clock release returns.
// - events in low power are latched once each, serviced back in Normal.
// - snoop in Stop-Grant or HALT enters a snoop state until serviced.
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module cslps_core import cslps_pkg::*; #(
    parameter int NCORES = NCORES_DEF,
    parameter bit ENG_SAMPLE = 1'b0,
    parameter logic [RATIO_W-1:0] RATED_RATIO = RATED_RATIO_DEF,
    parameter logic [RATIO_W-1:0] LOW_RATIO = LOW_RATIO_DEF,
    parameter logic [VID_W-1:0] VID_NOM = VID_NOM_DEF,
    parameter logic [VID_W-1:0] VID_LOW = VID_LOW_DEF
) (
    input wire logic sys_clk_in, // 40 MHz bus clock
    input wire logic arst_n_in, // block reset, active low
    input wire logic cpu_reset_n_in, // reset pin from chipset
    input wire logic stop_clock_request_n_in, // stop clock pin
    input wire logic system_mgmt_interrupt_n_in, // smi pin
    input wire logic warm_restart_n_in, // warm restart pin
    input wire logic [1:0] local_interrupt_pins_in, // local interrupts, high active
    input wire logic self_test_strap_n_in, // self test strap
    input wire logic bus_parking_disable_strap_n_in, // parking strap
    input wire logic arbitration_id_strap_n_in, // arbitration strap
    input wire logic [NCORES-1:0] cores_halted_in, // per core halt/monitor_wait
    input wire logic snoop_start_in, // snoop seen on bus, pulse
    input wire logic snoop_done_in, // snoop serviced by any agent, pulse
    input wire logic sgack_resp_in, // acknowledge cycle response phase, pulse
    input wire logic smi_strap_n_in, // smi pin sampled as tristate strap
    input wire logic [ADDR_W-1:0] reg_addr_in, // register address
    input wire logic [DATA_W-1:0] reg_wdata_in, // write data
    input wire logic reg_wr_in, // write strobe
    input wire logic reg_rd_in, // read strobe
    output logic [DATA_W-1:0] reg_rdata_out, // read data, cycle after strobe
    output logic sgack_req_out, // issue acknowledge special cycle
    output cslps_state_e state_out, // power state
    output cslps_strap_s strap_out, // captured straps
    output logic [RATIO_W-1:0] core_ratio_out, // core to bus ratio
    output logic [VID_W-1:0] voltage_id_code_out, // voltage code
    output logic [EVT_W-1:0] evt_service_out, // events to service, pulse
    output logic reinit_out // initialise pulse on reset pin
);

    initial begin
        if (NCORES < 1) $error("cslps_core: NCORES must be at least 1");
        if (SG_DELAY_CLKS < 2 || SG_DELAY_CLKS > 32) $error("cslps_core: stop-grant delay out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [PIN_W-1:0] pins_raw, pins;

    assign pins_raw = {arbitration_id_strap_n_in, bus_parking_disable_strap_n_in,
                       self_test_strap_n_in, local_interrupt_pins_in,
                       warm_restart_n_in, system_mgmt_interrupt_n_in,
                       stop_clock_request_n_in, cpu_reset_n_in};

    cslps_pin_sync #(.WIDTH(PIN_W), .RST_VAL(PIN_IDLE)) u_pins (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .pin_in(pins_raw),
        .stable_out(pins)
    );

    logic smi_strap_n;

    // the smi pin doubles as a strap; a separate copy keeps the lanes independent
    cslps_pin_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_smi_strap (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .pin_in(smi_strap_n_in),
        .stable_out(smi_strap_n)
    );

    logic rst_act, stop_clock_request_n_act, break_evt;
    logic [EVT_W-1:0] evt_lvl;
    cslps_strap_s strap_now;

    assign rst_act = !pins[P_RST];
    assign stop_clock_request_n_act = !pins[P_STOP_CLOCK_REQUEST_N];
    assign evt_lvl = {pins[P_LINT1], pins[P_LINT0], !pins[P_INIT], !pins[P_SMI]};
    assign break_evt = |evt_lvl;
    assign strap_now = '{arb_id: !pins[P_ARB], park_disable: !pins[P_PARK],
                         self_test: !pins[P_BIST], out_tristate: !smi_strap_n};

    ////////////////////////////////////////////////////////////////////////
    // straps, ratio and reset edges

    logic rst_prev_q, rst_prev_d, reinit_q, reinit_d, release_evt;
    cslps_strap_s strap_q, strap_d;
    logic [RATIO_W-1:0] ratio_q, ratio_d, ratio_req_q, ratio_req_d;
    logic ehalt_en_q, ehalt_en_d;

    assign release_evt = rst_prev_q && !rst_act;

    always_comb begin
        rst_prev_d = rst_act;
        reinit_d = rst_act && !rst_prev_q;
        strap_d = strap_q;
        ratio_d = ratio_q;
        if (release_evt) begin
            strap_d = strap_now;
            ratio_d = ENG_SAMPLE ? ratio_req_q : RATED_RATIO;
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_prev_q <= 1'b0;
            reinit_q <= 1'b0;
            strap_q <= STRAP_RST;
            ratio_q <= RATED_RATIO;
        end else begin
            rst_prev_q <= rst_prev_d;
            reinit_q <= reinit_d;
            strap_q <= strap_d;
            ratio_q <= ratio_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // low power state machine

    cslps_state_e state_q, state_d;
    logic from_halt_q, from_halt_d, ret_eh_q, ret_eh_d;
    logic ratio_low_q, ratio_low_d, vid_low_q, vid_low_d;
    logic [4:0] cnt_q, cnt_d;
    logic sg_hold;

    // a stop clock sequence in flight is not disturbed by the reset pin
    assign sg_hold = state_q inside {ST_SGACK, ST_SG_CNT, ST_STOP_GRANT, ST_SG_SNOOP};

    always_comb begin
        state_d = state_q;
        from_halt_d = from_halt_q;
        ret_eh_d = ret_eh_q;
        ratio_low_d = ratio_low_q;
        vid_low_d = vid_low_q;
        cnt_d = cnt_q;
        if (rst_act && !sg_hold) begin
            state_d = ST_NORMAL;
            ratio_low_d = 1'b0;
            vid_low_d = 1'b0;
        end else begin
            unique case (state_q)
                ST_NORMAL: begin
                    if (stop_clock_request_n_act) begin
                        state_d = ST_SGACK;
                        from_halt_d = 1'b0;
                    end else if (&cores_halted_in) begin
                        if (ehalt_en_q) begin
                            state_d = ST_EH_RATIO;
                            ratio_low_d = 1'b1;
                        end else begin
                            state_d = ST_HALT;
                        end
                    end
                end
                ST_HALT: begin
                    if (snoop_start_in) begin
                        state_d = ST_HALT_SNOOP;
                        ret_eh_d = 1'b0;
                    end else if (stop_clock_request_n_act) begin
                        state_d = ST_SGACK;
                        from_halt_d = 1'b1;
                    end else if (break_evt) begin
                        state_d = ST_NORMAL;
                    end
                end
                ST_EH_RATIO: begin
                    state_d = ST_EHALT;
                    vid_low_d = 1'b1;
                end
                ST_EHALT: begin
                    if (snoop_start_in) begin
                        state_d = ST_HALT_SNOOP;
                        ret_eh_d = 1'b1;
                    end else if (break_evt || stop_clock_request_n_act) begin
                        state_d = ST_EH_VID;
                        vid_low_d = 1'b0;
                    end
                end
                ST_EH_VID: begin
                    state_d = ST_NORMAL;
                    ratio_low_d = 1'b0;
                end
                ST_SGACK: begin
                    if (sgack_resp_in) begin
                        state_d = ST_SG_CNT;
                        cnt_d = 5'(SG_DELAY_CLKS - 1);
                    end
                end
                ST_SG_CNT: begin
                    cnt_d = cnt_q - 5'h01;
                    if (cnt_q == 5'h01) begin
                        state_d = ST_STOP_GRANT;
                    end
                end
                ST_STOP_GRANT: begin
                    if (snoop_start_in) begin
                        state_d = ST_SG_SNOOP;
                    end else if (!stop_clock_request_n_act) begin
                        state_d = from_halt_q ? ST_HALT : ST_NORMAL;
                    end
                end
                ST_HALT_SNOOP: begin
                    if (snoop_done_in) begin
                        state_d = ret_eh_q ? ST_EHALT : ST_HALT;
                    end
                end
                ST_SG_SNOOP: begin
                    if (snoop_done_in) begin
                        state_d = ST_STOP_GRANT;
                    end
                end
                default: begin
                    state_d = ST_NORMAL;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= ST_NORMAL;
            from_halt_q <= 1'b0;
            ret_eh_q <= 1'b0;
            ratio_low_q <= 1'b0;
            vid_low_q <= 1'b0;
            cnt_q <= 5'h00;
        end else begin
            state_q <= state_d;
            from_halt_q <= from_halt_d;
            ret_eh_q <= ret_eh_d;
            ratio_low_q <= ratio_low_d;
            vid_low_q <= vid_low_d;
            cnt_q <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event latching: pending clears in Normal or on the reset pin; outside Normal an edge in the same cycle still sets

    logic [EVT_W-1:0] evt_prev_q, evt_prev_d, pend_q, pend_d, serv_q, serv_d, evt_rise;

    assign evt_rise = evt_lvl & ~evt_prev_q;

    always_comb begin
        evt_prev_d = evt_lvl;
        if (state_q == ST_NORMAL) begin
            serv_d = pend_q | evt_rise;
            pend_d = '0;
        end else begin
            serv_d = '0;
            pend_d = pend_q | evt_rise;
        end
        if (rst_act) begin
            // initialise drops old events, but outside Normal an edge in the same cycle still sets
            pend_d = (state_q == ST_NORMAL) ? '0 : evt_rise;
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            evt_prev_q <= '0;
            pend_q <= '0;
            serv_q <= '0;
        end else begin
            evt_prev_q <= evt_prev_d;
            pend_q <= pend_d;
            serv_q <= serv_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register port

    logic [DATA_W-1:0] rdata_q, rdata_d;

    always_comb begin
        ehalt_en_d = ehalt_en_q;
        ratio_req_d = ratio_req_q;
        rdata_d = '0;
        if (reg_wr_in && reg_addr_in == ADDR_CTRL) begin
            ehalt_en_d = reg_wdata_in[CTRL_EHALT_BIT];
            if (ENG_SAMPLE) begin
                ratio_req_d = reg_wdata_in[CTRL_RATIO_LSB +: RATIO_W];
            end
        end
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                ADDR_CTRL: begin
                    rdata_d[CTRL_EHALT_BIT] = ehalt_en_q;
                    rdata_d[CTRL_RATIO_LSB +: RATIO_W] = ratio_q;
                end
                ADDR_STAT: begin
                    rdata_d[STAT_STATE_LSB +: 4] = state_q;
                    rdata_d[STAT_RLOW_BIT] = ratio_low_q;
                    rdata_d[STAT_VLOW_BIT] = vid_low_q;
                    rdata_d[STAT_PEND_LSB +: EVT_W] = pend_q;
                end
                ADDR_STRAP: begin
                    rdata_d[$bits(cslps_strap_s)-1:0] = strap_q;
                end
                default: begin
                    rdata_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ehalt_en_q <= 1'b0;
            ratio_req_q <= RATED_RATIO;
            rdata_q <= '0;
        end else begin
            ehalt_en_q <= ehalt_en_d;
            ratio_req_q <= ratio_req_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign sgack_req_out = (state_q == ST_SGACK);
    assign state_out = state_q;
    assign strap_out = strap_q;
    assign core_ratio_out = ratio_low_q ? LOW_RATIO : ratio_q;
    assign voltage_id_code_out = vid_low_q ? VID_LOW : VID_NOM;
    assign evt_service_out = serv_q;
    assign reinit_out = reinit_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);

    property p_strap_capture;
        release_evt |=> strap_q == $past(strap_now);
    endproperty
    a_strap_capture: assert property (p_strap_capture) else $error("straps not captured");

    property p_strap_hold;
        !release_evt |=> $stable(strap_q);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("straps changed");

    property p_ratio_locked;
        !ENG_SAMPLE |-> ratio_q == RATED_RATIO;
    endproperty
    a_ratio_locked: assert property (p_ratio_locked) else $error("ratio not locked");

    property p_halt_entry;
        state_q == ST_NORMAL && state_d inside {ST_HALT, ST_EH_RATIO} |-> &cores_halted_in;
    endproperty
    a_halt_entry: assert property (p_halt_entry) else $error("halt without all cores");

    property p_halt_break;
        state_q == ST_HALT && break_evt && !stop_clock_request_n_act && !snoop_start_in |=> state_q == ST_NORMAL;
    endproperty
    a_halt_break: assert property (p_halt_break) else $error("halt break ignored");

    property p_sg_back_halt;
        state_q == ST_STOP_GRANT && from_halt_q && !stop_clock_request_n_act && !snoop_start_in |=> state_q == ST_HALT;
    endproperty
    a_sg_back_halt: assert property (p_sg_back_halt) else $error("not back to halt");

    property p_ehalt_select;
        $past(state_q) == ST_NORMAL && state_q inside {ST_HALT, ST_EH_RATIO}
            |-> (state_q == ST_EH_RATIO) == $past(ehalt_en_q);
    endproperty
    a_ehalt_select: assert property (p_ehalt_select) else $error("wrong powerdown state");

    property p_eh_entry_order;
        state_q == ST_EH_RATIO && !rst_act |-> ratio_low_q && !vid_low_q ##1 state_q == ST_EHALT && vid_low_q;
    endproperty
    a_eh_entry_order: assert property (p_eh_entry_order) else $error("entry order wrong");

    property p_eh_exit_order;
        state_q == ST_EH_VID |-> ratio_low_q && !vid_low_q ##1 state_q == ST_NORMAL && !ratio_low_q;
    endproperty
    a_eh_exit_order: assert property (p_eh_exit_order) else $error("exit order wrong");

    property p_eh_snoop;
        state_q == ST_EHALT && snoop_start_in && !rst_act |=> state_q == ST_HALT_SNOOP ##0 ret_eh_q;
    endproperty
    a_eh_snoop: assert property (p_eh_snoop) else $error("snoop lost in ext halt");

    property p_sg_delay;
        state_q == ST_SGACK && sgack_resp_in |-> ##20 state_q == ST_STOP_GRANT;
    endproperty
    a_sg_delay: assert property (p_sg_delay) else $error("stop-grant delay wrong");

    property p_sg_reset;
        state_q == ST_STOP_GRANT && rst_act && stop_clock_request_n_act && !snoop_start_in |=> state_q == ST_STOP_GRANT;
    endproperty
    a_sg_reset: assert property (p_sg_reset) else $error("reset left stop-grant");

    property p_evt_latch;
        state_q != ST_NORMAL && evt_rise != '0 && !rst_act |=> evt_service_out == '0 && (pend_q & $past(evt_rise)) != '0;
    endproperty
    a_evt_latch: assert property (p_evt_latch) else $error("event not latched");

    property p_snoop_return;
        state_q == ST_SG_SNOOP && snoop_done_in |=> state_q == ST_STOP_GRANT;
    endproperty
    a_snoop_return: assert property (p_snoop_return) else $error("snoop no return");

    property p_sgack_issue;
        state_q == ST_SG_CNT |-> $past(sgack_req_out) || $past(state_q) == ST_SG_CNT;
    endproperty
    a_sgack_issue: assert property (p_sgack_issue) else $error("countdown without ack");

endmodule // cslps_core

// ### testbench/cslps_chipset_model.sv
`timescale 1ns/1ps
module cslps_chipset_model #(
    parameter int ACK_DLY = 3
) (
    input wire logic clk_in, // bus clock
    input wire logic sgack_req_in, // acknowledge cycle on bus
    input wire logic snoop_go_in, // bench asks for one snoop
    output logic sgack_resp_out = 1'b0, // response phase pulse
    output logic snoop_start_out = 1'b0, // snoop seen pulse
    output logic snoop_done_out = 1'b0 // snoop serviced pulse
);
    int ack_cnt = 0;
    int snp_cnt = 0;
    ////////////////////////////////////////
    // ack delay knob: a slow chipset must not change the 20-clock count
    always @(posedge clk_in) begin
        sgack_resp_out <= 1'b0;
        snoop_start_out <= 1'b0;
        snoop_done_out <= 1'b0;
        ack_cnt <= (sgack_req_in && !sgack_resp_out) ? ack_cnt + 1 : 0;
        if (sgack_req_in && ack_cnt == ACK_DLY) begin
            sgack_resp_out <= 1'b1;
        end
        if (snoop_go_in && snp_cnt == 0) begin
            snoop_start_out <= 1'b1;
            snp_cnt <= 1;
        end else if (snp_cnt == 4) begin
            snoop_done_out <= 1'b1;
            snp_cnt <= 0;
        end else if (snp_cnt > 0) begin
            snp_cnt <= snp_cnt + 1;
        end
    end
endmodule // cslps_chipset_model

// ### testbench/cpu_strap_and_low_power_states_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module cpu_strap_and_low_power_states_tb;
    import cslps_pkg::*;
    logic sys_clk_in = 0, arst_n_in = 0, cpu_reset_n_in = 0, stop_clock_request_n_in = 1, warm_restart_n_in = 1;
    logic system_mgmt_interrupt_n_in = 0, self_test_strap_n_in = 0, arbitration_id_strap_n_in = 0;
    logic bus_parking_disable_strap_n_in = 1, reg_wr_in = 0, reg_rd_in = 0, snoop_go = 0;
    logic [1:0] local_interrupt_pins_in = 2'h0, cores_halted_in = 2'h0;
    logic [7:0] reg_addr_in = 8'h00, core_ratio_out;
    logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, rd_val;
    logic sgack_resp_in, snoop_start_in, snoop_done_in, sgack_req_out, reinit_out;
    cslps_state_e state_out;
    cslps_strap_s strap_out;
    logic [5:0] voltage_id_code_out;
    logic [3:0] evt_service_out;
    int failures = 0, total_checks = 0, n, k, evt_cnt[5] = '{0, 0, 0, 0, 0};
    always #12.5 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) begin
        for (int i = 0; i < 4; i++) begin
            if (evt_service_out[i] === 1'b1) evt_cnt[i]++;
        end
        if (reinit_out === 1'b1) evt_cnt[4]++;
    end
    cslps_core uut (.sys_clk_in, .arst_n_in, .cpu_reset_n_in, .stop_clock_request_n_in, .system_mgmt_interrupt_n_in,
        .warm_restart_n_in, .local_interrupt_pins_in, .self_test_strap_n_in, .bus_parking_disable_strap_n_in,
        .arbitration_id_strap_n_in, .cores_halted_in, .snoop_start_in, .snoop_done_in, .sgack_resp_in,
        .smi_strap_n_in(system_mgmt_interrupt_n_in), .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
        .reg_rdata_out, .sgack_req_out, .state_out, .strap_out, .core_ratio_out, .voltage_id_code_out,
        .evt_service_out, .reinit_out);
    cslps_chipset_model far (.clk_in(sys_clk_in), .sgack_req_in(sgack_req_out), .snoop_go_in(snoop_go),
        .sgack_resp_out(sgack_resp_in), .snoop_start_out(snoop_start_in), .snoop_done_out(snoop_done_in));
    ////////////////////////////////////////
    task stop_test;
        if (failures == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task cyc(input int c);
        repeat (c) @(posedge sys_clk_in);
    endtask
    task wait_st(input cslps_state_e s, input int lim);
        n = 0;
        while (state_out !== s) begin
            if (n == lim) begin
                failures++;
                stop_test;
            end
            @(posedge sys_clk_in);
            #1;
            n++;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
        #1 rd_val = reg_rdata_out;
    endtask
    task snoop;
        @(posedge sys_clk_in);
        snoop_go <= 1'b1;
        @(posedge sys_clk_in);
        snoop_go <= 1'b0;
    endtask
    ////////////////////////////////////////
    task t_straps;
        cyc(8);
        cpu_reset_n_in <= 1'b1;
        cyc(8);
        self_test_strap_n_in <= 1'b1;
        arbitration_id_strap_n_in <= 1'b1;
        system_mgmt_interrupt_n_in <= 1'b1;
        bus_parking_disable_strap_n_in <= 1'b0;
        cyc(8);
        rd(ADDR_STRAP);
        `CHK(rd_val[3:0], 4'hb)
        `CHK(strap_out, 4'hb)
        cpu_reset_n_in <= 1'b0;
        cyc(8);
        cpu_reset_n_in <= 1'b1;
        cyc(8);
        bus_parking_disable_strap_n_in <= 1'b1;
        cyc(6);
        #1 `CHK(strap_out, 4'h4)
        // ratio field must not move on a production part
        wr(ADDR_CTRL, 32'h0000_3300);
        rd(ADDR_CTRL);
        `CHK(rd_val[15:8], RATED_RATIO_DEF)
        `CHK(core_ratio_out, RATED_RATIO_DEF)
        rd(8'h40);
        `CHK(rd_val, 32'h0)
    endtask
    task t_halt;
        @(posedge sys_clk_in);
        cores_halted_in <= 2'h1;
        cyc(6);
        #1 `CHK(state_out, ST_NORMAL)
        @(posedge sys_clk_in);
        cores_halted_in <= 2'h3;
        wait_st(ST_HALT, 4);
        k = evt_cnt[2];
        @(posedge sys_clk_in);
        cores_halted_in <= 2'h0;
        local_interrupt_pins_in <= 2'h1;
        wait_st(ST_NORMAL, 10);
        cyc(3);
        local_interrupt_pins_in <= 2'h0;
        #1 `CHK(evt_cnt[2] - k, 1)
        // interrupt level must clear the filter, else it breaks the next halt at once
        cyc(6);
        cores_halted_in <= 2'h3;
        wait_st(ST_HALT, 4);
        @(posedge sys_clk_in);
        cores_halted_in <= 2'h0;
        stop_clock_request_n_in <= 1'b0;
        wait_st(ST_STOP_GRANT, 60);
        @(posedge sys_clk_in);
        stop_clock_request_n_in <= 1'b1;
        wait_st(ST_HALT, 10);
        @(posedge sys_clk_in);
        system_mgmt_interrupt_n_in <= 1'b0;
        wait_st(ST_NORMAL, 10);
        @(posedge sys_clk_in);
        system_mgmt_interrupt_n_in <= 1'b1;
    endtask
    task t_ehalt;
        wr(ADDR_CTRL, 32'h1);
        cores_halted_in <= 2'h3;
        wait_st(ST_EH_RATIO, 4);
        `CHK({core_ratio_out, voltage_id_code_out}, {LOW_RATIO_DEF, VID_NOM_DEF})
        wait_st(ST_EHALT, 1);
        `CHK(voltage_id_code_out, VID_LOW_DEF)
        snoop;
        wait_st(ST_HALT_SNOOP, 4);
        wait_st(ST_EHALT, 8);
        @(posedge sys_clk_in);
        cores_halted_in <= 2'h0;
        warm_restart_n_in <= 1'b0;
        wait_st(ST_EH_VID, 8);
        `CHK({core_ratio_out, voltage_id_code_out}, {LOW_RATIO_DEF, VID_NOM_DEF})
        wait_st(ST_NORMAL, 1);
        `CHK(core_ratio_out, RATED_RATIO_DEF)
        wr(ADDR_CTRL, 32'h0);
        warm_restart_n_in <= 1'b1;
    endtask
    task t_stop_grant;
        @(posedge sys_clk_in);
        stop_clock_request_n_in <= 1'b0;
        wait_st(ST_SGACK, 8);
        `CHK(sgack_req_out, 1'b1)
        wait_st(ST_SG_CNT, 20);
        wait_st(ST_STOP_GRANT, 40);
        `CHK(n, SG_DELAY_CLKS - 1)
        cpu_reset_n_in <= 1'b0;
        cyc(8);
        cpu_reset_n_in <= 1'b1;
        cyc(8);
        #1 `CHK(state_out, ST_STOP_GRANT)
        `CHK(evt_cnt[4], 3)
        // events latch once each outside Normal, so two smi edges in Stop-Grant must come back as one
        k = evt_cnt[0];
        repeat (2) begin
            @(posedge sys_clk_in);
            system_mgmt_interrupt_n_in <= 1'b0;
            cyc(6);
            system_mgmt_interrupt_n_in <= 1'b1;
            cyc(6);
        end
        snoop;
        wait_st(ST_SG_SNOOP, 4);
        wait_st(ST_STOP_GRANT, 8);
        @(posedge sys_clk_in);
        stop_clock_request_n_in <= 1'b1;
        wait_st(ST_NORMAL, 10);
        cyc(4);
        #1 `CHK(evt_cnt[0] - k, 1)
    endtask
    initial begin
        cyc(20);
        arst_n_in <= 1'b1;
        t_straps;
        t_halt;
        t_ehalt;
        t_stop_grant;
        stop_test;
    end
endmodule // cpu_strap_and_low_power_states_tb
